// ### rtl/lpc_cfg.svh
`ifndef LPC_CFG_SVH
`define LPC_CFG_SVH
`define LPC_A_CTRL     8'h00
`define LPC_A_GAMMA    8'h04
`define LPC_A_SHADE    8'h08
`define LPC_A_NV_IDX   8'h0C
`define LPC_A_NV_OFF   8'h10
`define LPC_A_NV_GAIN  8'h14
`define LPC_A_LUT_IDX  8'h18
`define LPC_A_LUT_DATA 8'h1C
`define LPC_A_PIXCNT   8'h20
`define LPC_CTRL_RST   8'h01
`define LPC_GAMMA_RST  12'h400
`define LPC_GAIN_ONE   12'h400
`define LPC_NPIX       64
`define LPC_FS12       12'hFFF
`define LPC_FS8        12'h0FF
`define LPC_F_GAM_EN   3
`define LPC_F_GAM_USR  4
`define LPC_F_OFF_EN   5
`define LPC_F_GAIN_EN  6
`define LPC_F_MODE12   7
`define LPC_S_BUSY     4
`endif

// ### rtl/lpc_pkg.sv
package lpc_pkg;
  typedef struct packed {
    logic        valid;
    logic        sol;
    logic [11:0] data;
  } lpc_pix_type;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } lpc_apb_req_type;
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } lpc_apb_rsp_type;
  typedef enum logic [1:0] {
    LPC_IDLE = 2'b01,
    LPC_COPY = 2'b10
  } lpc_cp_type;
endpackage : lpc_pkg

// ### rtl/lpc_top.sv
`timescale 1ns/1ps
`include "lpc_cfg.svh"
module lpc_top (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire lpc_pkg::lpc_apb_req_type apb_req,
  output      lpc_pkg::lpc_apb_rsp_type apb_rsp,
  input  wire lpc_pkg::lpc_pix_type     pix_in,
  output      lpc_pkg::lpc_pix_type     pix_out
);
  import lpc_pkg::*;

  localparam int NP = `LPC_NPIX;

  // Register state
  logic [7:0]  ctrl_r;
  logic [11:0] gamma_r;
  logic [5:0]  nv_idx_r;
  logic [11:0] lut_idx_r;
  logic [3:0]  act_r;
  logic [31:0] pixcnt_r;
  logic        pready_r;
  logic        pslverr_r;
  logic [31:0] prdata_r;

  // User sets in nonvolatile store; factory set has no write path
  logic [11:0] nv_uoff [NP];
  logic [11:0] nv_ugain [NP];
  // Working copies used by the pixel path
  logic [11:0] wk_foff [NP];
  logic [11:0] wk_fgain [NP];
  logic [11:0] wk_uoff [NP];
  logic [11:0] wk_ugain [NP];
  logic [11:0] lut [4096];

  lpc_cp_type  cp_st_r;
  logic [3:0]  cp_sel_r;
  logic [5:0]  cp_idx_r;

  // Factory offset: protected constant, no correction
  function automatic logic [11:0] fac_off(input logic [5:0] i);
    fac_off = 12'h000;
  endfunction : fac_off

  // Factory gain: protected constant, unity
  function automatic logic [11:0] fac_gain(input logic [5:0] i);
    fac_gain = `LPC_GAIN_ONE;
  endfunction : fac_gain

  // Saturate a signed intermediate to the 12-bit pixel range
  function automatic logic [11:0] clamp12(input logic signed [15:0] v);
    if (v < 0)
      clamp12 = 12'h000;
    else if (v > 16'sh0FFF)
      clamp12 = `LPC_FS12;
    else
      clamp12 = v[11:0];
  endfunction : clamp12

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a <= `LPC_A_PIXCNT) && (a[1:0] == 2'b00);
  endfunction : addr_ok

  logic apb_go;
  logic apb_wr;
  logic shade_wr;
  assign apb_go   = apb_req.psel & apb_req.penable;
  assign apb_wr   = apb_go & pready_r & apb_req.pwrite &
                    addr_ok(apb_req.paddr);
  assign shade_wr = apb_wr & (apb_req.paddr == `LPC_A_SHADE);

  // One wait state; pready and data come from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h00000000;
    end else begin
      pready_r  <= apb_go & ~pready_r;
      pslverr_r <= apb_go & ~pready_r & ~addr_ok(apb_req.paddr);
      if (apb_go & ~pready_r & ~apb_req.pwrite) begin
        unique case (apb_req.paddr)
          `LPC_A_CTRL:    prdata_r <= {24'h000000, ctrl_r};
          `LPC_A_GAMMA:   prdata_r <= {20'h00000, gamma_r};
          `LPC_A_SHADE:   prdata_r <= {27'h0000000,
                                       cp_st_r == LPC_COPY, act_r};
          `LPC_A_NV_IDX:  prdata_r <= {26'h0000000, nv_idx_r};
          `LPC_A_NV_OFF:  prdata_r <= {20'h00000, nv_uoff[nv_idx_r]};
          `LPC_A_NV_GAIN: prdata_r <= {20'h00000, nv_ugain[nv_idx_r]};
          `LPC_A_LUT_IDX: prdata_r <= {20'h00000, lut_idx_r};
          `LPC_A_LUT_DATA: prdata_r <= {20'h00000, lut[lut_idx_r]};
          `LPC_A_PIXCNT:  prdata_r <= pixcnt_r;
          default:        prdata_r <= 32'h00000000;
        endcase
      end else begin
        prdata_r <= 32'h00000000;
      end
    end
  end

  // Control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r    <= `LPC_CTRL_RST;
      gamma_r   <= `LPC_GAMMA_RST;
      nv_idx_r  <= 6'h00;
      lut_idx_r <= 12'h000;
    end else if (apb_wr) begin
      unique case (apb_req.paddr)
        `LPC_A_CTRL:    ctrl_r <= apb_req.pwdata[7:0];
        `LPC_A_GAMMA:   gamma_r <= apb_req.pwdata[11:0];
        `LPC_A_NV_IDX:  nv_idx_r <= apb_req.pwdata[5:0];
        `LPC_A_LUT_IDX: lut_idx_r <= apb_req.pwdata[11:0];
        default: ;
      endcase
    end
  end

  // Memory writes; only the user set is writable
  always_ff @(posedge pclk) begin
    if (apb_wr && apb_req.paddr == `LPC_A_NV_OFF)
      nv_uoff[nv_idx_r] <= apb_req.pwdata[11:0];
    if (apb_wr && apb_req.paddr == `LPC_A_NV_GAIN)
      nv_ugain[nv_idx_r] <= apb_req.pwdata[11:0];
    if (apb_wr && apb_req.paddr == `LPC_A_LUT_DATA)
      lut[lut_idx_r] <= apb_req.pwdata[11:0];
  end

  // Activation engine: a set is live only after a full copy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cp_st_r  <= LPC_IDLE;
      cp_sel_r <= 4'h0;
      cp_idx_r <= 6'h00;
      act_r    <= 4'h0;
    end else begin
      unique case (cp_st_r)
        LPC_IDLE: begin
          // Commands during a copy are ignored
          if (shade_wr && apb_req.pwdata[3:0] != 4'h0) begin
            cp_sel_r <= apb_req.pwdata[3:0];
            act_r    <= act_r & ~apb_req.pwdata[3:0];
            cp_idx_r <= 6'h00;
            cp_st_r  <= LPC_COPY;
          end
        end
        LPC_COPY: begin
          cp_idx_r <= cp_idx_r + 6'h01;
          if (cp_idx_r == 6'(NP - 1)) begin
            act_r   <= act_r | cp_sel_r;
            cp_st_r <= LPC_IDLE;
          end
        end
      endcase
    end
  end

  // Copy nonvolatile content into working memory
  always_ff @(posedge pclk) begin
    if (cp_st_r == LPC_COPY) begin
      if (cp_sel_r[0])
        wk_foff[cp_idx_r] <= fac_off(cp_idx_r);
      if (cp_sel_r[1])
        wk_uoff[cp_idx_r] <= nv_uoff[cp_idx_r];
      if (cp_sel_r[2])
        wk_fgain[cp_idx_r] <= fac_gain(cp_idx_r);
      if (cp_sel_r[3])
        wk_ugain[cp_idx_r] <= nv_ugain[cp_idx_r];
    end
  end

  // Stage 1: pixel index and offset correction
  logic [5:0]         pidx_r;
  logic [5:0]         idx_cur;
  logic               off_on;
  logic               gain_on;
  logic signed [15:0] off_sum;
  logic [23:0]        gprod;
  logic [11:0]        gf;
  logic [11:0]        gu;
  lpc_pix_type        s1_r;
  logic [13:0]        gain_r;

  assign idx_cur = pix_in.sol ? 6'h00 : pidx_r;
  assign off_on  = ctrl_r[`LPC_F_OFF_EN] & (act_r[1:0] != 2'b00);
  assign gain_on = ctrl_r[`LPC_F_GAIN_EN] & (act_r[3:2] != 2'b00);
  // Factory and user offsets add up; either one also applies alone when only it is active
  assign off_sum =
    (act_r[0] ? 16'($signed(wk_foff[idx_cur])) : 16'sh0000) +
    (act_r[1] ? 16'($signed(wk_uoff[idx_cur])) : 16'sh0000);
  assign gf = act_r[2] ? wk_fgain[idx_cur] : `LPC_GAIN_ONE;
  assign gu = act_r[3] ? wk_ugain[idx_cur] : `LPC_GAIN_ONE;
  assign gprod = gf * gu;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pidx_r <= 6'h00;
      s1_r   <= '0;
      gain_r <= 14'h0400;
    end else begin
      if (pix_in.valid)
        pidx_r <= idx_cur + 6'h01;
      s1_r.valid <= pix_in.valid;
      s1_r.sol   <= pix_in.sol;
      s1_r.data  <= off_on ?
        clamp12(16'($signed({4'h0, pix_in.data})) + off_sum)
        : pix_in.data;
      gain_r <= gain_on ? gprod[23:10] : 14'h0400;
    end
  end

  // Stage 2: gain correction, 4.10 fixed-point factor
  logic [25:0] gmul;
  lpc_pix_type s2_r;
  assign gmul = s1_r.data * gain_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s2_r <= '0;
    end else begin
      s2_r.valid <= s1_r.valid;
      s2_r.sol   <= s1_r.sol;
      s2_r.data  <= (gmul[25:22] != 4'h0) ? `LPC_FS12
                                          : gmul[21:10];
    end
  end

  // Stage 3: horizontal binning; factor taken at line start
  logic [2:0]  bin_cfg;
  logic [2:0]  bin_n_r;
  logic [2:0]  bin_now;
  logic [1:0]  bcnt_r;
  logic [1:0]  bcnt_cur;
  logic [13:0] bacc_r;
  logic [13:0] bsum;
  logic        bfirst_r;
  lpc_pix_type s3_r;

  // Illegal codes fall back to no binning
  assign bin_cfg  = (ctrl_r[2:0] >= 3'd2 && ctrl_r[2:0] <= 3'd4) ?
                    ctrl_r[2:0] : 3'd1;
  assign bin_now  = s2_r.sol ? bin_cfg : bin_n_r;
  assign bcnt_cur = s2_r.sol ? 2'd0 : bcnt_r;
  assign bsum     = (bcnt_cur == 2'd0 ? 14'h0000 : bacc_r) +
                    {2'b00, s2_r.data};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bin_n_r  <= 3'd1;
      bcnt_r   <= 2'd0;
      bacc_r   <= 14'h0000;
      bfirst_r <= 1'b0;
      s3_r     <= '0;
    end else begin
      s3_r.valid <= 1'b0;
      if (s2_r.valid) begin
        bin_n_r <= bin_now;
        if ({1'b0, bcnt_cur} == bin_now - 3'd1) begin
          s3_r.valid <= 1'b1;
          s3_r.sol   <= s2_r.sol | bfirst_r;
          s3_r.data  <= clamp12({2'b00, bsum});
          bcnt_r     <= 2'd0;
          bfirst_r   <= 1'b0;
        end else begin
          bacc_r   <= bsum;
          bcnt_r   <= bcnt_cur + 2'd1;
          bfirst_r <= s2_r.sol | bfirst_r;
        end
      end
    end
  end

  // Stage 4: gamma through the table, endpoints and unity bypassed
  logic [11:0] gfs;
  logic [11:0] gin;
  logic [11:0] glut;
  logic        gam_on;
  assign gfs    = ctrl_r[`LPC_F_MODE12] ? `LPC_FS12 : `LPC_FS8;
  assign gin    = ctrl_r[`LPC_F_MODE12] ? s3_r.data
                                        : {4'h0, s3_r.data[11:4]};
  assign glut   = lut[gin];
  assign gam_on = ctrl_r[`LPC_F_GAM_EN] & ctrl_r[`LPC_F_GAM_USR] &
                  (gamma_r != `LPC_GAMMA_RST) &
                  (gin != 12'h000) & (gin != gfs);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pix_out  <= '0;
      pixcnt_r <= 32'h00000000;
    end else begin
      pix_out.valid <= s3_r.valid;
      pix_out.sol   <= s3_r.sol;
      if (gam_on)
        pix_out.data <= (glut > gfs) ? gfs : glut;
      else
        pix_out.data <= gin;
      if (s3_r.valid)
        pixcnt_r <= pixcnt_r + 32'h00000001;
    end
  end

  assign apb_rsp.pready  = pready_r;
  assign apb_rsp.pslverr = pslverr_r;
  assign apb_rsp.prdata  = prdata_r;
endmodule : lpc_top

// ### testbench/lpc_checker_assertions.sv
`timescale 1ns/1ps
module lpc_checker (
  input wire logic                     pclk,
  input wire logic                     presetn,
  input wire lpc_pkg::lpc_apb_req_type apb_req,
  input wire lpc_pkg::lpc_apb_rsp_type apb_rsp,
  input wire lpc_pkg::lpc_pix_type     pix_in,
  input wire lpc_pkg::lpc_pix_type     pix_out
);
  import lpc_pkg::*;
  logic        [7:0]  ctrl_r;
  logic               prev_sol_r;
  logic        [11:0] prev_d_r;
  wire logic   [12:0] pair_sum = {1'b0, prev_d_r} + {1'b0, pix_in.data};
  wire logic          bin_off = !(ctrl_r[2:0] inside {3'd2, 3'd3, 3'd4});
  wire logic          plain = bin_off && ctrl_r[6:5] == 2'b00;
  wire logic          raw = plain && ctrl_r[7] && !(ctrl_r[3] && ctrl_r[4]);
  function automatic logic [11:0] sat(input logic [12:0] s);
    return s[12] ? 12'hFFF : s[11:0];
  endfunction : sat
  // Shadow of the control word, taken only at the accepting edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= 8'h01;
    end else if (apb_req.psel && apb_req.penable && apb_req.pwrite &&
                 apb_rsp.pready && apb_req.paddr == 8'h00) begin
      ctrl_r <= apb_req.pwdata[7:0];
    end
  end
  // Previous pixel, so a two-pixel bin sum can be formed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_sol_r <= 1'b0;
      prev_d_r   <= 12'h000;
    end else begin
      prev_sol_r <= pix_in.valid && pix_in.sol;
      prev_d_r   <= pix_in.data;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_lat;
    bin_off && pix_in.valid |-> ##4 pix_out.valid;
  endproperty
  a_lat: assert property (p_lat) else $error("output pixel late");
  property p_idle;
    bin_off && !pix_in.valid |-> ##4 !pix_out.valid;
  endproperty
  a_idle: assert property (p_idle) else $error("spurious pixel");
  property p_sol;
    bin_off && pix_in.valid && pix_in.sol |-> ##4 pix_out.sol;
  endproperty
  a_sol: assert property (p_sol) else $error("line start lost");
  property p_zero;
    plain && pix_in.valid && pix_in.data == 12'h000 |-> ##4
      pix_out.data == 12'h000;
  endproperty
  a_zero: assert property (p_zero) else $error("black altered");
  property p_top;
    plain && ctrl_r[7] && pix_in.valid && pix_in.data == 12'hFFF |-> ##4
      pix_out.data == 12'hFFF;
  endproperty
  a_top: assert property (p_top) else $error("white altered");
  property p_pass;
    raw && pix_in.valid |-> ##4 pix_out.data == $past(pix_in.data, 4);
  endproperty
  a_pass: assert property (p_pass) else $error("pixel altered");
  property p_narrow;
    plain && ctrl_r[7:3] == 5'b00000 && pix_in.valid |-> ##4
      pix_out.data == ($past(pix_in.data, 4) >> 4);
  endproperty
  a_narrow: assert property (p_narrow) else $error("8-bit wrong");
  property p_bin2;
    ctrl_r == 8'h82 && pix_in.valid && !pix_in.sol && prev_sol_r |-> ##4
      pix_out.valid && pix_out.data == sat($past(pair_sum, 4));
  endproperty
  a_bin2: assert property (p_bin2) else $error("bin sum wrong");
  c_sol: cover property (pix_out.valid && pix_out.sol);
  c_err: cover property (apb_rsp.pslverr);
  c_bin4: cover property (ctrl_r[2:0] == 3'd4 && pix_out.valid);
endmodule : lpc_checker
bind lpc_top lpc_checker u_chk (.pclk(pclk), .presetn(presetn),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .pix_in(pix_in), .pix_out(pix_out));

// ### testbench/lpc_sensor_model.sv
`timescale 1ns/1ps
module lpc_sensor_model (
  input  wire logic                 pclk,
  output      lpc_pkg::lpc_pix_type pix
);
  import lpc_pkg::*;
  logic [11:0] line_q[$];
  initial pix = '0;
  // Idle cycles show the inverted last value, so stale data never passes
  task automatic run(input int gap);
    logic [11:0] last;
    last = 12'h000;
    foreach (line_q[i]) begin
      @(posedge pclk);
      pix <= '{1'b1, i == 0, line_q[i]};
      last = line_q[i];
      repeat (gap) begin
        @(posedge pclk);
        pix <= '{1'b0, 1'b0, ~last};
      end
    end
    @(posedge pclk);
    pix <= '{1'b0, 1'b0, ~last};
  endtask : run
endmodule : lpc_sensor_model

// ### testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import lpc_pkg::*;
  logic            pclk = 1'b0;
  logic            presetn = 1'b0;
  lpc_apb_req_type apb_req = '0;
  lpc_apb_rsp_type apb_rsp;
  lpc_pix_type     pix_in;
  lpc_pix_type     pix_out;
  int              fails = 0;
  int              n_compared = 0;
  logic [11:0]     out_q[$];
  logic [11:0]     exp_q[$];
  logic [31:0]     rd;
  logic            err;
  always #2 pclk = ~pclk;
  lpc_top u_dut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .pix_in(pix_in), .pix_out(pix_out));
  lpc_sensor_model u_sen (.pclk(pclk), .pix(pix_in));
  // Capture on the falling edge, where registered outputs have settled
  always @(negedge pclk) begin
    if (pix_out.valid === 1'b1)
      out_q.push_back(pix_out.data);
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test();
    $display("Mismatches %0d, comparisons %0d", fails, n_compared);
    if (fails == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  // One APB transfer; request holds until pready is sampled at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    // No cycle limit of its own; the watchdog ends a hung wait
    do begin
      @(posedge pclk);
    end while (apb_rsp.pready !== 1'b1);
    // Values read here are those the slave showed at this very edge
    rd  = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
  endtask : apb
  task automatic px(input logic [11:0] v, input logic [11:0] e);
    u_sen.line_q.push_back(v);
    exp_q.push_back(e);
  endtask : px
  // Send a line, let the pipeline drain, compare every output pixel
  task automatic line(input int gap);
    u_sen.run(gap);
    repeat (8) @(posedge pclk);
    check(out_q.size(), exp_q.size());
    foreach (exp_q[i]) check(out_q[i], exp_q[i]);
    out_q.delete();
    exp_q.delete();
    u_sen.line_q.delete();
  endtask : line
  task automatic t_regs();
    apb(0, 8'h00, 0);
    check(rd, 32'h01);
    apb(1, 8'h04, 32'hFFF);
    apb(0, 8'h04, 0);
    check(rd, 32'hFFF);
    apb(0, 8'h24, 0);
    check(err, 1'b1);
    check(rd, 0);
    apb(1, 8'h04, 32'h400);
    apb(1, 8'h00, 32'h81);
    px(12'h123, 12'h123);
    px(12'h000, 12'h000);
    px(12'hFFF, 12'hFFF);
    line(2);
    // Without binning every input pixel leaves as one output pixel
    apb(0, 8'h20, 0);
    check(rd, 32'h00000003);
  endtask : t_regs
  // Bins of 2, 3, 4 with a saturating first group and a dropped tail
  task automatic t_bin();
    int          s;
    logic [11:0] v;
    for (int n = 2; n <= 4; n++) begin
      apb(1, 8'h00, 32'h80 | n);
      s = 0;
      for (int i = 0; i < 12; i++) begin
        v = (i < n) ? 12'hC00 : 12'(i * 37);
        u_sen.line_q.push_back(v);
        s += v;
        if (i % n == n - 1) begin
          exp_q.push_back(s > 4095 ? 12'hFFF : 12'(s));
          s = 0;
        end
      end
      u_sen.line_q.push_back(12'h111);
      line(n - 2);
    end
  endtask : t_bin
  task automatic t_gamma();
    apb(1, 8'h18, 0);
    apb(1, 8'h1C, 32'h55);
    apb(1, 8'h18, 100);
    apb(1, 8'h1C, 7);
    apb(1, 8'h18, 32'hFFF);
    apb(1, 8'h1C, 32'h123);
    apb(1, 8'h04, 32'h800);
    apb(1, 8'h00, 32'h98);
    px(0, 0);
    px(100, 7);
    px(12'hFFF, 12'hFFF);
    line(0);
    apb(1, 8'h00, 32'h88);
    px(100, 100);
    line(0);
    apb(1, 8'h00, 32'h19);
    px(12'hFF0, 12'h0FF);
    px(12'h640, 12'h007);
    line(0);
    apb(1, 8'h00, 32'h98);
    apb(1, 8'h04, 32'h400);
    px(100, 100);
    line(0);
    apb(1, 8'h00, 32'h01);
    px(12'h7F3, 12'h07F);
    line(0);
  endtask : t_gamma
  // Shading acts only once a set is active; offset and gain each alone
  task automatic t_shade();
    int n;
    apb(1, 8'h00, 32'hE0);
    px(100, 100);
    px(100, 100);
    line(0);
    for (int i = 0; i < 2; i++) begin
      apb(1, 8'h0C, i);
      apb(1, 8'h10, i ? 0 : 5);
      apb(1, 8'h14, i ? 32'h800 : 32'h400);
    end
    apb(1, 8'h08, 32'hF);
    n = 0;
    do begin
      apb(0, 8'h08, 0);
      n++;
    end while (rd[4] !== 1'b0 && n < 100);
    check(rd[3:0], 4'hF);
    apb(1, 8'h00, 32'hE0);
    px(100, 105);
    px(100, 200);
    line(0);
    apb(1, 8'h00, 32'hA0);
    px(100, 105);
    px(100, 100);
    line(0);
    apb(1, 8'h00, 32'hC0);
    px(100, 100);
    px(100, 200);
    line(0);
  endtask : t_shade
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_bin();
    t_gamma();
    t_shade();
    end_of_test();
  end
  // Watchdog well beyond the few hundred cycles the run needs
  initial begin
    #100000;
    fails++;
    end_of_test();
  end
endmodule : tb_top
